// ==== shared/imgc_pkg.sv ====
// constants for the input mux and gain configuration register bank
// assumes one 250 MHz clock and an 8-bit register address space
package imgc_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 4;
	localparam int MOD_PERIOD_NS_DEF = 244;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] ADDR_INPUT_SEL = 8'h02;
	localparam logic [7:0] ADDR_GAIN_SET = 8'h03;
	localparam logic [7:0] RST_INPUT_SEL = 8'h01;
	localparam logic [7:0] RST_GAIN_SET = 8'h00;

	// ****************************************
	// field positions
	// ****************************************
	localparam int POS_CODE_LSB = 4;
	localparam int NEG_CODE_LSB = 0;
	localparam int CODE_W = 4;
	localparam int DELAY_LSB = 5;
	localparam int DELAY_W = 3;
	localparam int AMP_MODE_LSB = 3;
	localparam int AMP_MODE_W = 2;
	localparam int GAIN_LSB = 0;
	localparam int GAIN_W = 3;

	// ****************************************
	// codes
	// ****************************************
	localparam logic [3:0] CODE_COMMON = 4'hC;
	localparam logic [3:0] CODE_FIRST_WIDE = 4'h6;
	localparam int SEL_W = 13;
	localparam int PERIODS_W = 13;

	typedef enum logic [1:0] {
		IMGC_AMP_BYPASS = 2'h0,
		IMGC_AMP_ACTIVE = 2'h1,
		IMGC_AMP_RSVD2 = 2'h2,
		IMGC_AMP_RSVD3 = 2'h3
	} imgc_amp_mode_t;

	// delay code to modulator periods
	function automatic logic [12:0] delay_periods(input logic [2:0] code);
		case (code)
			3'h0: delay_periods = 13'h000E;
			3'h1: delay_periods = 13'h0019;
			3'h2: delay_periods = 13'h0040;
			3'h3: delay_periods = 13'h0100;
			3'h4: delay_periods = 13'h0400;
			3'h5: delay_periods = 13'h0800;
			3'h6: delay_periods = 13'h1000;
			default: delay_periods = 13'h0001;
		endcase
	endfunction

endpackage

// ==== shared/imgc_delay_if.sv ====
// carrier between the register bank and its conversion delay timer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface imgc_delay_if;
	logic start;
	logic [2:0] code;
	logic busy;
	logic fire;

	modport ctrl (output start, output code, input busy, input fire);
	modport timer (input start, input code, output busy, output fire);
endinterface

// ==== core/imgc_delay_timer.sv ====
// conversion delay timer counting modulator periods
// assumes start is a one-cycle pulse on the same clock
`timescale 1ns/1ps
module imgc_delay_timer #(
	parameter int MOD_DIV = 61
) (
	input wire logic clk_i, // system clock
	input wire logic reset_n_i, // async reset, active low
	imgc_delay_if.timer dly // start, code, busy, fire
);

	// ****************************************
	// divider and period counter
	// ****************************************
	logic [15:0] div_cnt;
	logic [15:0] next_div_cnt;
	logic [12:0] per_cnt;
	logic [12:0] next_per_cnt;
	logic busy;
	logic next_busy;
	logic fire;
	logic next_fire;

	always_comb begin
		next_div_cnt = div_cnt;
		next_per_cnt = per_cnt;
		next_busy = busy;
		next_fire = 1'b0;
		if (dly.start) begin
			// a new start restarts the wait from its full length
			next_div_cnt = 16'h0000;
			next_per_cnt = imgc_pkg::delay_periods(dly.code);
			next_busy = 1'b1;
		end else if (busy) begin
			if (div_cnt == 16'(MOD_DIV - 1)) begin
				next_div_cnt = 16'h0000;
				next_per_cnt = per_cnt - 13'h0001;
				if (per_cnt == 13'h0001) begin
					next_busy = 1'b0;
					next_fire = 1'b1;
				end
			end else begin
				next_div_cnt = div_cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			div_cnt <= 16'h0000;
			per_cnt <= 13'h0000;
			busy <= 1'b0;
			fire <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			per_cnt <= next_per_cnt;
			busy <= next_busy;
			fire <= next_fire;
		end
	end

	assign dly.busy = busy;
	assign dly.fire = fire;

	fire_single_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		fire |=> !fire)
		else $error("delay fire lasted more than one cycle");

endmodule

// ==== core/imgc_config_regs.sv ====
// input mux and amplifier gain configuration register bank
// assumes a same-clock register port with one-cycle strobes and
// restart requests coming from logic on the same clock
//
// Functional notes
// - positive input code in bits 7:4; codes 0..11 pick inputs 0..11, 12 common
// - negative input code in bits 3:0, same mapping as positive
// - input select register at 02h, resets to 01h
// - codes 6..11 valid only on the twelve-channel variant
// - delay field 7:5 sets wait before first conversion after restart
// - delay codes give 14,25,64,256,1024,2048,4096,1 modulator periods
// - amplifier mode 4:3: 00 bypass, 01 enabled, 10 and 11 reserved
// - gain field 2:0 sets gain two to the power of the code in mode 01, unity otherwise
// - gain register at 03h, resets to 00h
`timescale 1ns/1ps
module imgc_config_regs #(
	parameter bit TWELVE_CH = 1'b1,
	parameter int MOD_PERIOD_NS = imgc_pkg::MOD_PERIOD_NS_DEF
) (
	input wire logic CLK_I, // 250 MHz clock
	input wire logic RESET_N_I, // async reset, active low
	input wire logic [7:0] ADDR_I, // register address
	input wire logic [7:0] WDATA_I, // write data
	input wire logic WR_I, // write strobe
	input wire logic RD_I, // read strobe
	output logic [7:0] RDATA_O, // read data, cycle after read
	input wire logic RESTART_I, // filter reset and new conversion
	output logic [12:0] POS_SEL_O, // one-hot positive input, bit 12 common
	output logic [12:0] NEG_SEL_O, // one-hot negative input, bit 12 common
	output logic POS_VALID_O, // positive code names an input
	output logic NEG_VALID_O, // negative code names an input
	output logic AMP_ENABLE_O, // amplifier powered and in path
	output logic AMP_RSVD_O, // reserved amplifier mode written
	output logic [7:0] GAIN_FACTOR_O, // amplifier gain value
	output logic DELAY_BUSY_O, // waiting for first conversion
	output logic CONV_START_O // first conversion start pulse
);

	// ****************************************
	// timing
	// ****************************************
	localparam int MOD_DIV = (MOD_PERIOD_NS + imgc_pkg::CLK_PERIOD_NS - 1) / imgc_pkg::CLK_PERIOD_NS;

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic [12:0] decode_sel(input logic [3:0] code);
		logic [12:0] sel;
		sel = 13'h0000;
		if (code <= imgc_pkg::CODE_COMMON) begin
			sel = 13'h0001 << code;
		end
		if (!TWELVE_CH && code >= imgc_pkg::CODE_FIRST_WIDE && code < imgc_pkg::CODE_COMMON) begin
			sel = 13'h0000;
		end
		decode_sel = sel;
	endfunction

	function automatic logic [7:0] gain_value(input logic [2:0] code);
		gain_value = 8'h01 << code;
	endfunction

	// ****************************************
	// register file
	// ****************************************
	logic [7:0] input_sel;
	logic [7:0] next_input_sel;
	logic [7:0] gain_set;
	logic [7:0] next_gain_set;
	logic [7:0] rdata;
	logic [7:0] next_rdata;

	always_comb begin
		next_input_sel = input_sel;
		next_gain_set = gain_set;
		next_rdata = 8'h00;
		if (WR_I) begin
			case (ADDR_I)
				imgc_pkg::ADDR_INPUT_SEL: begin
					next_input_sel = WDATA_I;
				end
				imgc_pkg::ADDR_GAIN_SET: begin
					next_gain_set = WDATA_I;
				end
				default: begin
				end
			endcase
		end
		if (RD_I) begin
			case (ADDR_I)
				imgc_pkg::ADDR_INPUT_SEL: begin
					next_rdata = input_sel;
				end
				imgc_pkg::ADDR_GAIN_SET: begin
					next_rdata = gain_set;
				end
				default: begin
					next_rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			input_sel <= imgc_pkg::RST_INPUT_SEL;
			gain_set <= imgc_pkg::RST_GAIN_SET;
			rdata <= 8'h00;
		end else begin
			input_sel <= next_input_sel;
			gain_set <= next_gain_set;
			rdata <= next_rdata;
		end
	end

	assign RDATA_O = rdata;

	// ****************************************
	// decoded configuration
	// ****************************************
	logic [3:0] next_pos_code;
	logic [3:0] next_neg_code;
	logic [1:0] next_amp_mode;
	logic [12:0] pos_sel;
	logic [12:0] next_pos_sel;
	logic [12:0] neg_sel;
	logic [12:0] next_neg_sel;
	logic amp_en;
	logic next_amp_en;
	logic amp_rsvd;
	logic next_amp_rsvd;
	logic [7:0] gain_f;
	logic [7:0] next_gain_f;

	always_comb begin
		next_pos_code = next_input_sel[imgc_pkg::POS_CODE_LSB +: imgc_pkg::CODE_W];
		next_neg_code = next_input_sel[imgc_pkg::NEG_CODE_LSB +: imgc_pkg::CODE_W];
		next_amp_mode = next_gain_set[imgc_pkg::AMP_MODE_LSB +: imgc_pkg::AMP_MODE_W];
		next_pos_sel = decode_sel(next_pos_code);
		next_neg_sel = decode_sel(next_neg_code);
		next_amp_en = 1'b0;
		next_amp_rsvd = 1'b0;
		case (next_amp_mode)
			imgc_pkg::IMGC_AMP_BYPASS: begin
				next_amp_en = 1'b0;
			end
			imgc_pkg::IMGC_AMP_ACTIVE: begin
				next_amp_en = 1'b1;
			end
			default: begin
				// reserved codes keep the amplifier off but stay readable
				next_amp_rsvd = 1'b1;
			end
		endcase
		// in bypass the gain code is the host's duty; the path sees unity
		if (next_amp_en) begin
			next_gain_f = gain_value(next_gain_set[imgc_pkg::GAIN_LSB +: imgc_pkg::GAIN_W]);
		end else begin
			next_gain_f = 8'h01;
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			pos_sel <= 13'h0001;
			neg_sel <= 13'h0002;
			amp_en <= 1'b0;
			amp_rsvd <= 1'b0;
			gain_f <= 8'h01;
		end else begin
			pos_sel <= next_pos_sel;
			neg_sel <= next_neg_sel;
			amp_en <= next_amp_en;
			amp_rsvd <= next_amp_rsvd;
			gain_f <= next_gain_f;
		end
	end

	assign POS_SEL_O = pos_sel;
	assign NEG_SEL_O = neg_sel;
	assign POS_VALID_O = |pos_sel;
	assign NEG_VALID_O = |neg_sel;
	assign AMP_ENABLE_O = amp_en;
	assign AMP_RSVD_O = amp_rsvd;
	assign GAIN_FACTOR_O = gain_f;

	// ****************************************
	// conversion delay
	// ****************************************
	imgc_delay_if dly ();

	assign dly.start = RESTART_I;
	assign dly.code = gain_set[imgc_pkg::DELAY_LSB +: imgc_pkg::DELAY_W];

	imgc_delay_timer #(
		.MOD_DIV(MOD_DIV)
	) u_timer (
		.clk_i(CLK_I),
		.reset_n_i(RESET_N_I),
		.dly(dly)
	);

	assign DELAY_BUSY_O = dly.busy;
	assign CONV_START_O = dly.fire;

	// ****************************************
	// checks
	// ****************************************
	int wait_cycles;
	int wait_target;

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			wait_cycles <= 0;
			wait_target <= 0;
		end else if (RESTART_I) begin
			wait_cycles <= 0;
			wait_target <= int'(imgc_pkg::delay_periods(dly.code)) * MOD_DIV;
		end else if (dly.busy) begin
			wait_cycles <= wait_cycles + 1;
		end
	end

	sequence wr_input_s;
		WR_I && ADDR_I == imgc_pkg::ADDR_INPUT_SEL;
	endsequence

	sequence wr_gain_s;
		WR_I && ADDR_I == imgc_pkg::ADDR_GAIN_SET;
	endsequence

	sequence wr_then_rd_s;
		WR_I && (ADDR_I == imgc_pkg::ADDR_INPUT_SEL || ADDR_I == imgc_pkg::ADDR_GAIN_SET)
			##1 RD_I && ADDR_I == $past(ADDR_I);
	endsequence

	pos_select_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		wr_input_s |=> POS_SEL_O == decode_sel($past(WDATA_I[7:4])))
		else $error("positive select does not follow written code");

	neg_select_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		wr_input_s |=> NEG_SEL_O == decode_sel($past(WDATA_I[3:0])))
		else $error("negative select does not follow written code");

	input_reset_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		$rose(RESET_N_I) |-> input_sel == 8'h01 && POS_SEL_O[0] && NEG_SEL_O[1])
		else $error("input select reset value wrong");

	variant_limit_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		wr_input_s ##1 (!TWELVE_CH && input_sel[7:4] >= 4'h6 && input_sel[7:4] < 4'hC)
			|-> !POS_VALID_O && POS_SEL_O == 13'h0000)
		else $error("wide channel selected on six-channel variant");

	delay_start_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		RESTART_I |=> DELAY_BUSY_O && !CONV_START_O)
		else $error("restart did not begin the delay");

	delay_length_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CONV_START_O |-> wait_cycles == wait_target && !DELAY_BUSY_O)
		else $error("first conversion delay length wrong");

	amp_mode_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		wr_gain_s |=> AMP_ENABLE_O == ($past(WDATA_I[4:3]) == 2'h1)
			&& AMP_RSVD_O == $past(WDATA_I[4])) 
		else $error("amplifier mode decode wrong");

	gain_value_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		wr_gain_s ##0 WDATA_I[4:3] == 2'h1 |=> GAIN_FACTOR_O == (8'h01 << $past(WDATA_I[2:0])))
		else $error("gain factor wrong");

	gain_reset_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		$rose(RESET_N_I) |-> gain_set == 8'h00 && !AMP_ENABLE_O && GAIN_FACTOR_O == 8'h01)
		else $error("gain register reset value wrong");

	read_back_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		wr_then_rd_s |=> RDATA_O == $past(WDATA_I, 2))
		else $error("read back differs from written value");

	read_idle_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		!RD_I |=> RDATA_O == 8'h00)
		else $error("read data present without a read");

endmodule

// ==== bench/tb_top.sv ====
// self-checking bench for the input mux and gain configuration register bank
// assumes both bank variants on one 250 MHz clock; the bench drives every port itself
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
	$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module tb_top;
	localparam int MOD_NS = 8;
	localparam int DIV = (MOD_NS + imgc_pkg::CLK_PERIOD_NS - 1) / imgc_pkg::CLK_PERIOD_NS;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic restart = 1'b0;
	logic [7:0] rdata;
	logic [12:0] pos_sel;
	logic [12:0] neg_sel;
	logic [12:0] pos_sel6;
	logic [12:0] neg_sel6;
	logic pos_valid;
	logic neg_valid;
	logic amp_en;
	logic amp_rsvd;
	logic [7:0] gain;
	logic busy;
	logic conv_start;
	int errors = 0;
	int checks = 0;
	int in_reg = 1;
	int gain_reg = 0;
	int periods[8] = '{14, 25, 64, 256, 1024, 2048, 4096, 1};
	logic [7:0] d;
	logic [7:0] ua;

	imgc_config_regs #(.TWELVE_CH(1'b1), .MOD_PERIOD_NS(MOD_NS)) u_dut (.CLK_I(clk), .RESET_N_I(reset_n),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RESTART_I(restart),
		.POS_SEL_O(pos_sel), .NEG_SEL_O(neg_sel), .POS_VALID_O(pos_valid), .NEG_VALID_O(neg_valid),
		.AMP_ENABLE_O(amp_en), .AMP_RSVD_O(amp_rsvd), .GAIN_FACTOR_O(gain), .DELAY_BUSY_O(busy),
		.CONV_START_O(conv_start));
	// six-channel variant fed the same traffic
	imgc_config_regs #(.TWELVE_CH(1'b0), .MOD_PERIOD_NS(MOD_NS)) u_six (.CLK_I(clk), .RESET_N_I(reset_n),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(), .RESTART_I(restart),
		.POS_SEL_O(pos_sel6), .NEG_SEL_O(neg_sel6), .POS_VALID_O(), .NEG_VALID_O(),
		.AMP_ENABLE_O(), .AMP_RSVD_O(), .GAIN_FACTOR_O(), .DELAY_BUSY_O(), .CONV_START_O());

	initial begin
		forever #2 clk = ~clk;
	end

	// ****************************************
	// model and bus tasks
	// ****************************************
	function automatic int sel_exp(input int code, input bit twelve);
		if (code == 12) return 32'h1000;
		if (code < 12 && (twelve || code < 6)) return 1 << code;
		return 0;
	endfunction

	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		if (a == imgc_pkg::ADDR_INPUT_SEL) in_reg = v;
		if (a == imgc_pkg::ADDR_GAIN_SET) gain_reg = v;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
		@(posedge clk);
		#1;
		`CHK("read data after its cycle", 0, rdata)
	endtask

	// write strobe followed by a read strobe of the same register with no idle cycle
	task automatic write_then_read(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		if (a == imgc_pkg::ADDR_INPUT_SEL) in_reg = v;
		if (a == imgc_pkg::ADDR_GAIN_SET) gain_reg = v;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK("read right after write", (a == imgc_pkg::ADDR_INPUT_SEL) ? in_reg : gain_reg, rdata)
	endtask

	task automatic check_regs;
		int p;
		int n;
		int m;
		p = (in_reg >> 4) % 16;
		n = in_reg % 16;
		m = (gain_reg >> 3) % 4;
		reg_read(imgc_pkg::ADDR_INPUT_SEL, d);
		`CHK("input select readback", in_reg, d)
		reg_read(imgc_pkg::ADDR_GAIN_SET, d);
		`CHK("gain setting readback", gain_reg, d)
		`CHK("positive select", sel_exp(p, 1'b1), pos_sel)
		`CHK("negative select", sel_exp(n, 1'b1), neg_sel)
		`CHK("positive valid", sel_exp(p, 1'b1) != 0, pos_valid)
		`CHK("negative valid", sel_exp(n, 1'b1) != 0, neg_valid)
		`CHK("six-channel positive", sel_exp(p, 1'b0), pos_sel6)
		`CHK("six-channel negative", sel_exp(n, 1'b0), neg_sel6)
		`CHK("amplifier enable", m == 1, amp_en)
		`CHK("amplifier reserved", m >= 2, amp_rsvd)
		`CHK("gain factor", (m == 1) ? (1 << (gain_reg % 8)) : 1, gain)
	endtask

	task automatic pulse_restart;
		@(posedge clk);
		restart <= 1'b1;
		@(posedge clk);
		restart <= 1'b0;
	endtask

	task automatic run_delay(input int code, input bit again);
		int cnt;
		reg_write(imgc_pkg::ADDR_GAIN_SET, 8'(code * 32));
		pulse_restart();
		if (again) begin
			repeat (10) @(posedge clk);
			pulse_restart();
		end
		cnt = 0;
		do begin
			@(posedge clk);
			#1;
			cnt++;
			if (cnt == 1) `CHK("busy after restart", 1, busy)
		end while (conv_start !== 1'b1 && cnt < periods[code] * DIV + 10);
		if (conv_start !== 1'b1) begin
			errors++;
			report_and_stop();
		end
		`CHK("delay cycles", periods[code] * DIV, cnt)
		`CHK("busy in start cycle", 0, busy)
		@(posedge clk);
		#1;
		`CHK("start pulse length", 0, conv_start)
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(97));
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		check_regs();
		for (int c = 0; c < 16; c++) begin
			write_then_read(imgc_pkg::ADDR_INPUT_SEL, 8'((c << 4) | (15 - c)));
			check_regs();
		end
		for (int m = 0; m < 4; m++) begin
			for (int g = 0; g < 8; g++) begin
				// bypass always goes with unity gain
				write_then_read(imgc_pkg::ADDR_GAIN_SET, 8'((($urandom % 8) << 5) | (m << 3) | ((m == 0) ? 0 : g)));
				check_regs();
			end
		end
		for (int k = 0; k < 5; k++) begin
			ua = (k == 0) ? 8'h00 : 8'(4 + $urandom % 252);
			reg_write(ua, 8'($urandom));
			reg_read(ua, d);
			`CHK("unmapped read", 0, d)
			check_regs();
		end
		for (int c = 0; c < 8; c++) begin
			run_delay(c, 1'b0);
		end
		run_delay(0, 1'b1);
		reg_write(imgc_pkg::ADDR_INPUT_SEL, 8'($urandom));
		reg_write(imgc_pkg::ADDR_GAIN_SET, 8'hEB);
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		in_reg = 1;
		gain_reg = 0;
		check_regs();
		report_and_stop();
	end
endmodule
